/* core/cacr_top.sv */
// Register front end of the counter array: counter bytes with a high-byte
// snapshot, channel 0 compare and reload bytes, and output polarity.
// Assumes a single-cycle special-function-register bus on the system clock.
`timescale 1ns/10ps
`default_nettype none

// How it works
// R01: Counter low byte is readable and writable, resets to zero.
// R02: Counter high byte reads return a snapshot, not the live bits.
// R03: Snapshot refreshes from the live high byte only when the low byte is read.
// R04: Channel 0 compare low byte is readable and writable, resets to zero.
// R05: Channel 0 compare high byte is readable and writable, resets to zero.
// R06: Reload select steers both compare addresses to the auto-reload value.
// R07: Writing compare low byte clears the comparator function enable.
// R08: Writing compare high byte sets the comparator function enable.
// R09: Polarity register holds three channel bits, upper bits reserved, reset zero.
// R10: Polarity bit inverts its channel output at once when set.
// R11: Comparator function enable gates channel 0 compare matches.
// R12: Counter byte writes load the live counter, bypassing the snapshot.
module cacr_top (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  input wire logic i_count_en,
  input wire logic i_reload_select,
  input wire logic i_mode_wr,
  input wire logic i_mode_comparator_func_enable,
  output logic o_comparator_func_enable,
  output logic o_ch0_match,
  output logic [15:0] o_counter,
  output logic [15:0] o_ch0_compare,
  output logic [15:0] o_ch0_reload,
  input wire logic [2:0] i_chan_raw,
  output logic [2:0] o_chan_out
);

  cacr_cnt_if cnt_bus ();

  logic wr_pol;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_cmp_lo;
  logic wr_cmp_hi;
  logic rd_cnt_lo;
  logic [2:0] pol;
  logic [7:0] snap_q;
  logic [7:0] snap_d;
  logic [15:0] cmp_q;
  logic [15:0] cmp_d;
  logic [15:0] reload_q;
  logic [15:0] reload_d;
  logic cmp_en_q;
  logic cmp_en_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic hit_q;
  logic hit_d;
  logic match_q;
  logic match_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  assign wr_pol = i_sfr_wr && (i_sfr_addr == cacr_pkg::OFS_OUTPUT_POLARITY);
  assign wr_cnt_lo = i_sfr_wr && (i_sfr_addr == cacr_pkg::OFS_COUNTER_LOW_BYTE);
  assign wr_cnt_hi = i_sfr_wr && (i_sfr_addr == cacr_pkg::OFS_COUNTER_HIGH_BYTE);
  assign wr_cmp_lo = i_sfr_wr && (i_sfr_addr == cacr_pkg::OFS_CHANNEL0_COMPARE_LOW);
  assign wr_cmp_hi = i_sfr_wr && (i_sfr_addr == cacr_pkg::OFS_CHANNEL0_COMPARE_HIGH);
  assign rd_cnt_lo = i_sfr_rd && (i_sfr_addr == cacr_pkg::OFS_COUNTER_LOW_BYTE);

  ////////////////////////////////////////////////////////////////////////////////
  // Counter core and its load path.
  assign cnt_bus.load_lo = wr_cnt_lo; // see R12
  assign cnt_bus.load_hi = wr_cnt_hi; // see R12
  assign cnt_bus.wdata = i_sfr_wdata;
  assign cnt_bus.step = i_count_en;

  cacr_counter u_counter (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .cnt(cnt_bus)
  );

  // The snapshot makes a low-then-high read pair coherent even if the counter
  // carries into its high byte between the two reads.
  always_comb begin
    snap_d = snap_q;
    if (rd_cnt_lo) begin
      snap_d = cnt_bus.value[15:8]; // see R03
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      snap_q <= cacr_pkg::RST_BYTE;
    end else begin
      snap_q <= snap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel 0 compare and auto-reload values, and the comparator enable.
  always_comb begin
    cmp_d = cmp_q;
    reload_d = reload_q;
    if (wr_cmp_lo) begin
      if (i_reload_select) begin
        reload_d[7:0] = i_sfr_wdata; // see R06
      end else begin
        cmp_d[7:0] = i_sfr_wdata; // see R04
      end
    end
    if (wr_cmp_hi) begin
      if (i_reload_select) begin
        reload_d[15:8] = i_sfr_wdata; // see R06
      end else begin
        cmp_d[15:8] = i_sfr_wdata; // see R05
      end
    end
  end

  // A compare byte write beats a mode register write in the same cycle.
  always_comb begin
    cmp_en_d = cmp_en_q;
    if (i_mode_wr) begin
      cmp_en_d = i_mode_comparator_func_enable;
    end
    if (wr_cmp_lo) begin
      cmp_en_d = 1'b0; // see R07
    end
    if (wr_cmp_hi) begin
      cmp_en_d = 1'b1; // see R08
    end
  end

  always_comb begin
    match_d = cmp_en_q && (cnt_bus.value == cmp_q); // see R11
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cmp_q <= cacr_pkg::RST_WORD;
      reload_q <= cacr_pkg::RST_WORD;
      cmp_en_q <= cacr_pkg::RST_COMPARATOR_FUNC_ENABLE;
      match_q <= 1'b0;
    end else begin
      cmp_q <= cmp_d;
      reload_q <= reload_d;
      cmp_en_q <= cmp_en_d;
      match_q <= match_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output polarity.
  cacr_polarity #(
    .NCH(cacr_pkg::NUM_CH)
  ) u_polarity (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_wr(wr_pol),
    .i_wdata(i_sfr_wdata[2:0]),
    .i_raw(i_chan_raw),
    .o_pol(pol),
    .o_out(o_chan_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux, registered; unmapped addresses answer zero with no hit.
  always_comb begin
    rdata_d = cacr_pkg::RST_BYTE;
    hit_d = 1'b0;
    if (i_sfr_rd) begin
      hit_d = 1'b1;
      case (i_sfr_addr)
        cacr_pkg::OFS_OUTPUT_POLARITY: begin
          rdata_d = {cacr_pkg::POLARITY_RESERVED_READ, pol}; // see R09
        end
        cacr_pkg::OFS_COUNTER_LOW_BYTE: begin
          rdata_d = cnt_bus.value[7:0]; // see R01
        end
        cacr_pkg::OFS_COUNTER_HIGH_BYTE: begin
          rdata_d = snap_q; // see R02
        end
        cacr_pkg::OFS_CHANNEL0_COMPARE_LOW: begin
          rdata_d = i_reload_select ? reload_q[7:0] : cmp_q[7:0]; // see R06
        end
        cacr_pkg::OFS_CHANNEL0_COMPARE_HIGH: begin
          rdata_d = i_reload_select ? reload_q[15:8] : cmp_q[15:8]; // see R06
        end
        default: begin
          hit_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= cacr_pkg::RST_BYTE;
      hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign o_sfr_rdata = rdata_q;
  assign o_sfr_hit = hit_q;
  assign o_comparator_func_enable = cmp_en_q;
  assign o_ch0_match = match_q;
  assign o_counter = cnt_bus.value;
  assign o_ch0_compare = cmp_q;
  assign o_ch0_reload = reload_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_low_read;
    i_sfr_rd && (i_sfr_addr == cacr_pkg::OFS_COUNTER_LOW_BYTE);
  endsequence

  sequence s_high_read;
    i_sfr_rd && (i_sfr_addr == cacr_pkg::OFS_COUNTER_HIGH_BYTE);
  endsequence

  sequence s_cmp_lo_write;
    i_sfr_wr && (i_sfr_addr == cacr_pkg::OFS_CHANNEL0_COMPARE_LOW);
  endsequence

  sequence s_cmp_hi_write;
    i_sfr_wr && (i_sfr_addr == cacr_pkg::OFS_CHANNEL0_COMPARE_HIGH);
  endsequence

  AST_LOW_READ_LIVE: assert property ( // see R01
    s_low_read |=> (o_sfr_rdata == $past(o_counter[7:0])) && o_sfr_hit)
    else $error("Counter low byte read did not return the live low byte.");

  AST_HIGH_READ_SNAPSHOT: assert property ( // see R02
    s_high_read |=> o_sfr_rdata == $past(snap_q))
    else $error("Counter high byte read did not return the snapshot.");

  AST_SNAPSHOT_ON_LOW_READ: assert property ( // see R03
    s_low_read ##1 s_high_read |=> o_sfr_rdata == $past(o_counter[15:8], 2))
    else $error("Low then high read pair was not coherent.");

  AST_SNAPSHOT_HOLDS: assert property ( // see R03
    !rd_cnt_lo |=> $stable(snap_q))
    else $error("Snapshot changed without a counter low byte read.");

  AST_CMP_LO_STORE: assert property ( // see R04
    (s_cmp_lo_write and !i_reload_select) |=>
      (cmp_q[7:0] == $past(i_sfr_wdata)) && $stable(reload_q))
    else $error("Compare low byte write was not stored in the compare value.");

  AST_CMP_HI_STORE: assert property ( // see R05
    (s_cmp_hi_write and !i_reload_select) |=>
      (cmp_q[15:8] == $past(i_sfr_wdata)) && $stable(reload_q))
    else $error("Compare high byte write was not stored in the compare value.");

  AST_RELOAD_STEER: assert property ( // see R06
    (s_cmp_hi_write and i_reload_select) |=>
      (reload_q[15:8] == $past(i_sfr_wdata)) && $stable(cmp_q))
    else $error("Reload select did not steer the write to the reload value.");

  AST_CMP_LO_CLEARS_EN: assert property ( // see R07
    (s_cmp_lo_write and !wr_cmp_hi) |=> !o_comparator_func_enable)
    else $error("Compare low byte write did not clear the comparator enable.");

  AST_CMP_HI_SETS_EN: assert property ( // see R08
    s_cmp_hi_write |=> o_comparator_func_enable ##1
      (o_comparator_func_enable || $past(i_mode_wr) || $past(wr_cmp_lo)))
    else $error("Compare high byte write did not set the comparator enable.");

  AST_POL_RESERVED: assert property ( // see R09
    (i_sfr_rd && (i_sfr_addr == cacr_pkg::OFS_OUTPUT_POLARITY)) |=>
      o_sfr_rdata[7:3] == cacr_pkg::POLARITY_RESERVED_READ)
    else $error("Reserved polarity bits did not read as zero.");

  AST_POL_IMMEDIATE: assert property ( // see R10
    wr_pol |=> o_chan_out == (i_chan_raw ^ $past(i_sfr_wdata[2:0])))
    else $error("Polarity change did not reach the channel outputs at once.");

  AST_MATCH_GATED: assert property ( // see R11
    !o_comparator_func_enable |=> !o_ch0_match)
    else $error("Compare match raised while the comparator was disabled.");

  AST_CNT_WRITE_BYPASS: assert property ( // see R12
    wr_cnt_hi && !i_sfr_rd |=> (o_counter[15:8] == $past(i_sfr_wdata)) && $stable(snap_q))
    else $error("Counter high byte write did not load the live counter.");

endmodule
`default_nettype wire

/* common/cacr_pkg.sv */
// Constants for the counter array register block: register offsets, widths
// and reset values.
// Assumes an 8-bit special-function-register bus with byte addresses.
package cacr_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned NUM_CH = 3;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFS_OUTPUT_POLARITY = 8'h96;
  localparam logic [7:0] OFS_COUNTER_LOW_BYTE = 8'hF9;
  localparam logic [7:0] OFS_COUNTER_HIGH_BYTE = 8'hFA;
  localparam logic [7:0] OFS_CHANNEL0_COMPARE_LOW = 8'hFB;
  localparam logic [7:0] OFS_CHANNEL0_COMPARE_HIGH = 8'hFC;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [2:0] RST_POLARITY = 3'h0;
  localparam logic [4:0] POLARITY_RESERVED_READ = 5'h00;
  localparam logic RST_COMPARATOR_FUNC_ENABLE = 1'b0;

endpackage

/* common/cacr_cnt_if.sv */
// Link between the register front end and the 16-bit counter core.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface cacr_cnt_if;
  logic load_lo;
  logic load_hi;
  logic [7:0] wdata;
  logic step;
  logic [15:0] value;

  modport ctl (output load_lo, output load_hi, output wdata, output step, input value);
  modport cnt (input load_lo, input load_hi, input wdata, input step, output value);
endinterface
`default_nettype wire

/* core/cacr_counter.sv */
// The 16-bit counter/timer core with byte-wise software loads.
// Assumes the step input is a one-cycle enable pulse from the clock source.
`timescale 1ns/10ps
`default_nettype none
module cacr_counter (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  cacr_cnt_if.cnt cnt
);

  logic [15:0] count_q;
  logic [15:0] count_d;

  ////////////////////////////////////////////////////////////////////////////////
  // A software byte load wins over a count step in the same cycle for that byte only; the other byte still steps, carry included.
  always_comb begin
    count_d = count_q;
    if (cnt.step) begin
      count_d = count_q + 16'h0001;
    end
    if (cnt.load_lo) begin
      count_d[7:0] = cnt.wdata; // see R12
    end
    if (cnt.load_hi) begin
      count_d[15:8] = cnt.wdata; // see R12
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_q <= cacr_pkg::RST_WORD;
    end else begin
      count_q <= count_d;
    end
  end

  assign cnt.value = count_q;

endmodule
`default_nettype wire

/* core/cacr_polarity.sv */
// Per-channel output polarity bits and the inverting output stage.
// Assumes the raw channel levels come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cacr_polarity #(
  parameter int unsigned NCH = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_wr,
  input wire logic [NCH-1:0] i_wdata,
  input wire logic [NCH-1:0] i_raw,
  output logic [NCH-1:0] o_pol,
  output logic [NCH-1:0] o_out
);

  logic [NCH-1:0] pol_q;
  logic [NCH-1:0] pol_d;

  always_comb begin
    pol_d = pol_q;
    if (i_wr) begin
      pol_d = i_wdata; // see R09
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pol_q <= '0;
    end else begin
      pol_q <= pol_d;
    end
  end

  // The pin follows the polarity bit at once, so no counter event is awaited.
  assign o_out = i_raw ^ pol_q; // see R10
  assign o_pol = pol_q;

endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the counter array register front end.
// Assumes the single-cycle register bus of the top module, with read data one cycle late.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_count_en = 1'b0;
  logic i_reload_select = 1'b0;
  logic i_mode_wr = 1'b0;
  logic i_mode_comparator_func_enable = 1'b0;
  logic [2:0] i_chan_raw = 3'h0;
  logic [7:0] o_sfr_rdata;
  logic o_sfr_hit;
  logic o_comparator_func_enable;
  logic o_ch0_match;
  logic [15:0] o_counter;
  logic [15:0] o_ch0_compare;
  logic [15:0] o_ch0_reload;
  logic [2:0] o_chan_out;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] rd_data;
  logic rd_hit;

  cacr_top u_dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .i_count_en(i_count_en), .i_reload_select(i_reload_select),
    .i_mode_wr(i_mode_wr), .i_mode_comparator_func_enable(i_mode_comparator_func_enable),
    .o_comparator_func_enable(o_comparator_func_enable), .o_ch0_match(o_ch0_match),
    .o_counter(o_counter), .o_ch0_compare(o_ch0_compare), .o_ch0_reload(o_ch0_reload),
    .i_chan_raw(i_chan_raw), .o_chan_out(o_chan_out)
  );

  always #25 i_sys_clk = ~i_sys_clk;

  // The whole run needs under a hundred cycles, so a hang shows up well before this ceiling.
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    i_sfr_addr <= addr;
    i_sfr_wdata <= data;
    i_sfr_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_wr <= 1'b0;
    #1;
  endtask

  // Read data and hit are registered, so they are taken just after the edge that took the read.
  task automatic sfr_rd(input logic [7:0] addr);
    @(posedge i_sys_clk);
    i_sfr_addr <= addr;
    i_sfr_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_sfr_rd <= 1'b0;
    #1;
    rd_data = o_sfr_rdata;
    rd_hit = o_sfr_hit;
  endtask

  task automatic mode_write(input logic en);
    @(posedge i_sys_clk);
    i_mode_comparator_func_enable <= en;
    i_mode_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_mode_wr <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    sfr_rd(8'hF9);
    `CHK("counter_low", 8'h00, rd_data)
    `CHK("hit_low", 1'b1, rd_hit)
    sfr_rd(8'hFA);
    `CHK("counter_high", 8'h00, rd_data)
    sfr_rd(8'hFB);
    `CHK("cmp_low", 8'h00, rd_data)
    sfr_rd(8'hFC);
    `CHK("cmp_high", 8'h00, rd_data)
    sfr_rd(8'h96);
    `CHK("polarity", 8'h00, rd_data)
    `CHK("cmp_enable", 1'b0, o_comparator_func_enable)
    sfr_rd(8'h97);
    `CHK("unmapped_data", 8'h00, rd_data)
    `CHK("unmapped_hit", 1'b0, rd_hit)
  endtask

  task automatic test_snapshot();
    sfr_wr(8'hF9, 8'hFF);
    sfr_wr(8'hFA, 8'h12);
    `CHK("counter_loaded", 16'h12FF, o_counter)
    sfr_rd(8'hFA);
    `CHK("snap_untouched", 8'h00, rd_data)
    sfr_rd(8'hF9);
    `CHK("low_read", 8'hFF, rd_data)
    sfr_rd(8'hFA);
    `CHK("snap_refreshed", 8'h12, rd_data)
    @(posedge i_sys_clk);
    i_count_en <= 1'b1;
    @(posedge i_sys_clk);
    i_count_en <= 1'b0;
    #1;
    `CHK("counter_carry", 16'h1300, o_counter)
    sfr_rd(8'hFA);
    `CHK("snap_stale", 8'h12, rd_data)
    sfr_rd(8'hF9);
    `CHK("low_after_carry", 8'h00, rd_data)
    sfr_rd(8'hFA);
    `CHK("snap_after_carry", 8'h13, rd_data)
  endtask

  task automatic test_compare();
    mode_write(1'b1);
    `CHK("mode_enable", 1'b1, o_comparator_func_enable)
    sfr_wr(8'hFB, 8'h34);
    `CHK("low_clears", 1'b0, o_comparator_func_enable)
    sfr_wr(8'hFC, 8'h56);
    `CHK("high_sets", 1'b1, o_comparator_func_enable)
    `CHK("cmp_word", 16'h5634, o_ch0_compare)
    sfr_rd(8'hFB);
    `CHK("cmp_low_rd", 8'h34, rd_data)
    sfr_rd(8'hFC);
    `CHK("cmp_high_rd", 8'h56, rd_data)
    sfr_wr(8'hF9, 8'h34);
    sfr_wr(8'hFA, 8'h56);
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK("match_on", 1'b1, o_ch0_match)
    mode_write(1'b0);
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK("match_gated", 1'b0, o_ch0_match)
  endtask

  // Reload and compare share addresses, so a slip in the steering corrupts the other value.
  task automatic test_reload();
    @(posedge i_sys_clk);
    i_reload_select <= 1'b1;
    sfr_wr(8'hFC, 8'h9A);
    `CHK("reload_high_sets", 1'b1, o_comparator_func_enable)
    sfr_wr(8'hFB, 8'h78);
    `CHK("reload_low_clears", 1'b0, o_comparator_func_enable)
    `CHK("reload_word", 16'h9A78, o_ch0_reload)
    `CHK("cmp_kept", 16'h5634, o_ch0_compare)
    sfr_rd(8'hFB);
    `CHK("reload_low_rd", 8'h78, rd_data)
    sfr_rd(8'hFC);
    `CHK("reload_high_rd", 8'h9A, rd_data)
    @(posedge i_sys_clk);
    i_reload_select <= 1'b0;
    sfr_rd(8'hFB);
    `CHK("cmp_low_back", 8'h34, rd_data)
  endtask

  task automatic test_polarity();
    @(posedge i_sys_clk);
    i_chan_raw <= 3'h5;
    #1;
    `CHK("out_default", 3'h5, o_chan_out)
    sfr_wr(8'h96, 8'hFF);
    `CHK("out_inverted", 3'h2, o_chan_out)
    sfr_rd(8'h96);
    `CHK("pol_reserved", 8'h07, rd_data)
    sfr_wr(8'h96, 8'h02);
    `CHK("out_ch1_only", 3'h7, o_chan_out)
    sfr_rd(8'h96);
    `CHK("pol_ch1", 8'h02, rd_data)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    test_reset_values();
    test_snapshot();
    test_compare();
    test_reload();
    test_polarity();
    report_and_stop();
  end
endmodule
`undef CHK
`default_nettype wire
